/* File: verification/bus_slave_model.sv */
// Memory-like slave on one processor bus with a settable answer delay.
// Assumes one request at a time from the block, held until ack.
`timescale 1ns/10ps
`default_nettype none

module bus_slave_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req,
	input wire logic wr,
	input wire logic [15:0] addr,
	input wire logic [15:0] wd,
	input wire logic [3:0] dly,
	output logic ack,
	output logic [15:0] rd
);
	logic [15:0] mem [logic [15:0]];
	logic [3:0] cnt;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack <= 1'b0;
			cnt <= 4'h0;
			rd <= 16'h0;
		end
		else if (req && !ack && cnt >= dly)
		begin
			ack <= 1'b1;
			cnt <= 4'h0;
			if (wr)
				mem[addr] = wd;
			rd <= mem.exists(addr) ? mem[addr] : ~addr;
		end
		else
		begin
			ack <= 1'b0;
			cnt <= (req && !ack) ? cnt + 4'h1 : 4'h0;
			rd <= ~rd; // Released data flips to its inverse every cycle
		end
	end
endmodule : bus_slave_model
`default_nettype wire

/* File: verification/cpu_fetch_and_trap_control_properties.sv */
// Checker on the ports of the fetch and trap control block.
// Assumes the constants header is on the include path; bound below.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_fetch_trap_consts.svh"

module cpu_trap_properties
#(
	parameter int WORD_W = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dp_done,
	input wire logic [WORD_W-1:0] dp_addr,
	input wire logic [WORD_W-1:0] bus_addr,
	input wire logic sys_req,
	input wire logic sys_ack,
	input wire logic sys_foreign,
	input wire logic fast_req,
	input wire logic instr_boundary,
	input wire logic trap_active,
	input wire logic ctx_load,
	input wire logic ext_irq_ack,
	input wire logic [WORD_W-1:0] sp_in,
	input wire logic [WORD_W-1:0] sp_out,
	input wire logic [3:0] dec_class,
	input wire logic [1:0] seq_variant
);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_ir_fetch_only: assert property (
		$changed(dec_class) |-> dp_done)
		else $error("class changed off a transfer");
	chk_branch_variant: assert property (
		seq_variant[1] == (dec_class == `CLASS_BR))
		else $error("variant class bit wrong");
	chk_slverr_ready: assert property (
		pslverr |-> pready)
		else $error("error without ready");
	chk_apb_zero_wait: assert property (
		(psel && !penable && ce) ##1 (penable && ce) |-> pready)
		else $error("access cycle not ready");
	chk_foreign_quiet: assert property (
		sys_foreign |-> !sys_req)
		else $error("request while bus held");
	chk_addr_source: assert property (
		(sys_req || fast_req) && !trap_active |-> bus_addr == dp_addr)
		else $error("bus address not from datapath");
	chk_done_after_ack: assert property (
		sys_req && sys_ack && !trap_active |=> dp_done)
		else $error("no done after ack");
	chk_done_pulse: assert property (
		dp_done |=> !dp_done)
		else $error("done longer than a cycle");
	chk_trap_boundary: assert property (
		$rose(trap_active) |-> $past(instr_boundary))
		else $error("trap off a boundary");
	chk_trap_finish: assert property (
		$rose(trap_active) |-> ##[4:400] ctx_load)
		else $error("context not loaded");
	chk_ack_in_trap: assert property (
		ext_irq_ack |-> trap_active)
		else $error("device ack outside trap");
	chk_new_stack: assert property (
		ctx_load |=> sp_out == sp_in - `PUSH_TWO)
		else $error("stack pointer not pushed");
endmodule : cpu_trap_properties

bind cpu_fetch_and_trap_control cpu_trap_properties #(.WORD_W(WORD_W))
	cpu_trap_properties_i (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.dp_done(dp_done), .dp_addr(dp_addr), .bus_addr(bus_addr),
	.sys_req(sys_req), .sys_ack(sys_ack), .sys_foreign(sys_foreign),
	.fast_req(fast_req), .instr_boundary(instr_boundary),
	.trap_active(trap_active), .ctx_load(ctx_load),
	.ext_irq_ack(ext_irq_ack), .sp_in(sp_in), .sp_out(sp_out),
	.dec_class(dec_class), .seq_variant(seq_variant));
`default_nettype wire

/* File: verification/cpu_fetch_and_trap_control_tb_top.sv */
// Bench for the fetch and trap control block: APB master, datapath driver.
// Assumes bus_slave_model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_fetch_trap_consts.svh"

module cpu_fetch_and_trap_control_tb_top;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic dp_req, dp_write, dp_fetch, dp_fast, dp_done, dp_zero, dp_neg;
	logic dp_carry, instr_boundary, trap_active, ctx_load, ext_irq, err;
	logic ext_irq_ack, bus_write, sys_req, sys_ack, sys_foreign;
	logic fast_req, fast_ack;
	logic [1:0] seq_variant;
	logic [2:0] ext_irq_pri;
	logic [3:0] dec_class, sys_dly, fast_dly;
	logic [7:0] paddr;
	logic [15:0] dp_addr, dp_wdata, br_out, pc_in, sp_in, ctx_pc, sp_out;
	logic [15:0] psw_out, ext_irq_vec, bus_addr, bus_wdata;
	logic [15:0] sys_rdata, fast_rdata;
	logic [31:0] pwdata, prdata, rd;
	int fail_count = 0;
	int total_checks = 0;

	cpu_fetch_and_trap_control cpu_fetch_and_trap_control_i (.pclk(pclk),
		.presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .dp_req(dp_req),
		.dp_write(dp_write), .dp_fetch(dp_fetch), .dp_fast(dp_fast),
		.dp_addr(dp_addr), .dp_wdata(dp_wdata), .dp_done(dp_done),
		.br_out(br_out), .dp_zero(dp_zero), .dp_neg(dp_neg),
		.dp_carry(dp_carry), .dec_class(dec_class),
		.seq_variant(seq_variant), .instr_boundary(instr_boundary),
		.pc_in(pc_in), .sp_in(sp_in), .trap_active(trap_active),
		.ctx_load(ctx_load), .ctx_pc(ctx_pc), .sp_out(sp_out),
		.psw_out(psw_out), .ext_irq(ext_irq), .ext_irq_pri(ext_irq_pri),
		.ext_irq_vec(ext_irq_vec), .ext_irq_ack(ext_irq_ack),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
		.sys_req(sys_req), .sys_ack(sys_ack), .sys_foreign(sys_foreign),
		.sys_rdata(sys_rdata), .fast_req(fast_req), .fast_ack(fast_ack),
		.fast_rdata(fast_rdata));
	bus_slave_model sys_mem_i (.clk(pclk), .rst_n(presetn), .req(sys_req),
		.wr(bus_write), .addr(bus_addr), .wd(bus_wdata), .dly(sys_dly),
		.ack(sys_ack), .rd(sys_rdata));
	bus_slave_model fast_mem_i (.clk(pclk), .rst_n(presetn), .req(fast_req),
		.wr(bus_write), .addr(bus_addr), .wd(bus_wdata), .dly(fast_dly),
		.ack(fast_ack), .rd(fast_rdata));

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Mode bits are fetch, write, fast bus
	task automatic xfer(input logic [2:0] m, input logic [15:0] a, d);
		{dp_fetch, dp_write, dp_fast} <= m;
		dp_addr <= a;
		dp_wdata <= d;
		dp_req <= 1'b1;
		do
			@(posedge pclk);
		while (dp_done !== 1'b1);
		dp_req <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	task automatic put(input logic [15:0] a, d);
		sys_mem_i.mem[a] = d;
		fast_mem_i.mem[a] = d;
	endtask : put

	task automatic boundary;
		instr_boundary <= 1'b1;
		@(posedge pclk);
		instr_boundary <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : boundary

	task automatic service(input logic [15:0] pc, vec);
		pc_in <= pc;
		boundary();
		do
			@(posedge pclk);
		while (ctx_load !== 1'b1);
		check(ctx_pc, vec);
		@(posedge pclk);
	endtask : service

	task automatic t_regs;
		logic [7:0] a [6] = '{`REG_CTRL, `REG_STATUS, `REG_MASK,
			`REG_CAUSE, `REG_PSW, `REG_SWI};
		foreach (a[i])
		begin
			apb(1'b0, a[i], 32'h0);
			check(rd, {31'h0, i == 0});
		end
		// A frozen block leaves the access cycle waiting
		ce <= 1'b0;
		fork
			apb(1'b0, `REG_CTRL, 32'h0);
			begin
				repeat (4) @(posedge pclk);
				check(pready, 32'h0);
				ce <= 1'b1;
			end
		join
		check(rd, 32'h1);
		apb(1'b1, 8'h1C, 32'hFFFF);
		check(err, 32'h1);
		apb(1'b1, `REG_PSW, 32'hFFFF);
		apb(1'b0, `REG_PSW, 32'h0);
		check(rd, 32'h0);
	endtask : t_regs

	task automatic t_fetch;
		put(16'h0100, 16'h3A5C);
		put(16'h0102, 16'h5123);
		put(16'h0104, 16'h7001);
		xfer(3'h4, 16'h0100, 16'h0);
		check({br_out, dec_class}, 20'h3A5C3);
		xfer(3'h0, 16'h0102, 16'h0);
		check({br_out, dec_class}, 20'h51233);
		fast_dly <= 4'h3;
		xfer(3'h5, 16'h0104, 16'h0);
		check({br_out, dec_class}, 20'h70017);
		xfer(3'h2, 16'h0200, 16'hBEEF);
		check(sys_mem_i.mem[16'h0200], 16'hBEEF);
		sys_foreign <= 1'b1;
		fork
			xfer(3'h0, 16'h0200, 16'h0);
			repeat (6) @(posedge pclk);
		join_any
		sys_foreign <= 1'b0;
		wait fork;
		check(br_out, 16'hBEEF);
		check(irq, 32'h0);
		apb(1'b1, `REG_MASK, 32'h4);
		check(irq, 32'h1);
		apb(1'b0, `REG_STATUS, 32'h0);
		check(rd, 32'h4);
		check(irq, 32'h0);
	endtask : t_fetch

	task automatic t_variant;
		logic [15:0] ir;
		for (int k = 0; k < 16; k++)
		begin
			ir = {5'h0, k[2:0], 8'h0};
			put(16'h0300, ir);
			xfer(3'h4, 16'h0300, 16'h0);
			{dp_zero, dp_neg, dp_carry} <= {k[3], ~k[3], k[3]};
			@(posedge pclk);
			check(seq_variant, {1'b1, ir[8] ^ (ir[9] ? dp_zero :
				(ir[10] ? dp_neg : dp_carry))});
		end
	endtask : t_variant

	task automatic t_traps;
		xfer(3'h2, `SPR_SLIMIT, 16'h0800);
		xfer(3'h2, `SPR_PSW, 16'hC080);
		xfer(3'h0, `SPR_PSW, 16'h0);
		check(br_out, 16'hC080);
		apb(1'b0, `REG_SLIMIT, 32'h0);
		check(rd, 32'h800);
		xfer(3'h2, 16'h0100, 16'h1111);
		apb(1'b0, `REG_STATUS, 32'h0);
		check(rd[3:1], 3'h7);
		put(16'h0004, 16'h4000);
		put(16'h0006, 16'h0005);
		put(16'h0040, 16'h5000);
		put(16'h0042, 16'h00A0);
		put(16'h00A0, 16'h6000);
		put(16'h00A2, 16'h0000);
		{sys_dly, sp_in, ext_irq_vec} <= {4'h2, 16'h1000, 16'h0040};
		{ext_irq, ext_irq_pri} <= 4'hE;
		service(16'h2222, 16'h4000);
		check(sys_mem_i.mem[16'h0FFE], 16'hC080);
		check(sys_mem_i.mem[16'h0FFC], 16'h2222);
		check(psw_out, 16'h3005);
		apb(1'b1, `REG_CTRL, 32'h3);
		apb(1'b1, `REG_MASK, 32'h1);
		service(16'h2400, 16'h5000);
		ext_irq <= 1'b0;
		check(fast_mem_i.mem[16'h0FFE], 16'h3005);
		check({psw_out, irq}, 17'h00141);
		apb(1'b0, `REG_CAUSE, 32'h0);
		check(rd, 32'h2);
		xfer(3'h2, `SPR_SWI, 16'h0400);
		boundary();
		check(trap_active, 32'h0);
		xfer(3'h2, `SPR_SWI, 16'h8000);
		apb(1'b1, `REG_CTRL, 32'h0);
		boundary();
		check(trap_active, 32'h0);
		apb(1'b1, `REG_CTRL, 32'h1);
		service(16'h2600, 16'h6000);
		apb(1'b0, `REG_CAUSE, 32'h0);
		check(rd, 32'h3);
	endtask : t_traps

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, dp_req, dp_write, dp_fetch} = '0;
		{dp_fast, dp_addr, dp_wdata, dp_zero, dp_neg, dp_carry} = '0;
		{instr_boundary, pc_in, sp_in, ext_irq, ext_irq_pri} = '0;
		{ext_irq_vec, sys_foreign, sys_dly, fast_dly} = '0;
		ce = 1'b1;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_fetch();
		t_variant();
		t_traps();
		stop_test();
	end

	initial
	begin
		#400000;
		fail_count++;
		stop_test();
	end
endmodule : cpu_fetch_and_trap_control_tb_top
`default_nettype wire

/* File: verilog/cpu_fetch_and_trap_control.sv */
// Fetch, bus-transfer and trap control section of a 16-bit processor.
// Assumes a datapath that holds pc_in and sp_in steady while trap_active,
// bus slaves that answer with a one-cycle ack, and an APB master.
// Behaviour
// - Every word moving between the processor and any outside bus goes through the bus transfer register.
// - Transfer addresses come from the general registers and the control section drives the transfer strobes.
// - For simple slaves and every fast-bus device the processor drives address and control itself.
// - The instruction hold register is fed from the same inputs as the bus transfer register.
// - The instruction hold register loads only on instruction fetches, never on operand loads.
// - Instruction hold register outputs go only to decoding, never into the arithmetic datapath.
// - The sequence variant is chosen from datapath conditions together with the decoded instruction.
// - Accepting a condition saves status, next address, mode and register set, then loads a new context; the code pushes only psw_reg and pc_in, no register set.
// - Execution resumes at the service start address taken from the new context.
// - A response starts only when allowed, and conditions wait for the instruction in progress to end.
// - Special registers sit outside the core, written from and read into the bus transfer register.
// - The stack limit and software request registers signal which conditions exist.
// - The status word decides which existing conditions are answered; a stack limit condition is taken whatever the priority field.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_fetch_trap_consts.svh"

module cpu_fetch_and_trap_control
	import cpu_fetch_trap_pkg::*;
#(
	parameter int WORD_W = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic dp_req,
	input wire logic dp_write,
	input wire logic dp_fetch,
	input wire logic dp_fast,
	input wire logic [WORD_W-1:0] dp_addr,
	input wire logic [WORD_W-1:0] dp_wdata,
	output logic dp_done,
	output logic [WORD_W-1:0] br_out,
	input wire logic dp_zero,
	input wire logic dp_neg,
	input wire logic dp_carry,
	output logic [3:0] dec_class,
	output logic [1:0] seq_variant,
	input wire logic instr_boundary,
	input wire logic [WORD_W-1:0] pc_in,
	input wire logic [WORD_W-1:0] sp_in,
	output logic trap_active,
	output logic ctx_load,
	output logic [WORD_W-1:0] ctx_pc,
	output logic [WORD_W-1:0] sp_out,
	output logic [WORD_W-1:0] psw_out,
	input wire logic ext_irq,
	input wire logic [2:0] ext_irq_pri,
	input wire logic [WORD_W-1:0] ext_irq_vec,
	output logic ext_irq_ack,
	output logic [WORD_W-1:0] bus_addr,
	output logic [WORD_W-1:0] bus_wdata,
	output logic bus_write,
	output logic sys_req,
	input wire logic sys_ack,
	input wire logic sys_foreign,
	input wire logic [WORD_W-1:0] sys_rdata,
	output logic fast_req,
	input wire logic fast_ack,
	input wire logic [WORD_W-1:0] fast_rdata
);

	function automatic logic [2:0] top_level(input logic [6:0] req);
		logic [2:0] lvl;
		lvl = 3'h0;
		for (int i = 0; i < 7; i++)
		begin
			if (req[i])
				lvl = 3'(i + 1);
		end
		return lvl;
	endfunction : top_level

	function automatic logic [1:0] pick_variant(input logic [WORD_W-1:0] ir,
		input logic z, input logic n, input logic c);
		logic cond;
		cond = ir[`IR_SELZ] ? z : (ir[`IR_SELN] ? n : c);
		return {ir[`IR_CLASS] == `CLASS_BR, cond ^ ir[`IR_INV]};
	endfunction : pick_variant

	ctl_state_t state_reg, state_next;
	cause_t cause_reg, cause_next, sel;
	logic [WORD_W-1:0] bus_transfer_register, br_next;
	logic [WORD_W-1:0] instruction_hold_register, ir_next;
	logic [WORD_W-1:0] psw_reg, psw_next;
	logic [WORD_W-1:0] slimit_reg, slimit_next;
	logic [WORD_W-1:0] swi_reg, swi_next;
	logic [WORD_W-1:0] addr_reg, addr_next;
	logic [WORD_W-1:0] sp_reg, sp_next;
	logic [WORD_W-1:0] vec_reg, vec_next;
	logic [WORD_W-1:0] pc_new_reg, pc_new_next;
	logic write_reg, write_next;
	logic fetch_reg, fetch_next;
	logic fast_reg, fast_next;
	logic stkov_reg, stkov_next;
	logic done_reg, done_next;
	logic ctx_reg, ctx_next;
	logic iack_reg, iack_next;
	logic [`CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [`EV_W-1:0] status_reg, status_next;
	logic [`EV_W-1:0] mask_reg, mask_next;
	logic [`EV_W-1:0] events;
	logic [31:0] prdata_reg, prdata_next;
	logic lat_reg, lat_next;
	logic on_bus, ack, mapped, apb_wr, apb_rd;
	logic [WORD_W-1:0] in_word, spr_rd;
	logic [2:0] cur_pri;
	logic [2:0] swi_lvl;
	logic spr_hit;

	assign on_bus = state_reg inside {ST_DP, ST_TR_PSW, ST_TR_PC,
		ST_TR_VPC, ST_TR_VPSW};
	// Stand off the system bus while a foreign master owns it
	assign sys_req = on_bus && !fast_reg && !sys_foreign;
	assign fast_req = on_bus && fast_reg;
	assign ack = fast_reg ? fast_ack : (sys_ack && sys_req);
	// One input source feeds both the transfer and instruction registers
	assign in_word = fast_reg ? fast_rdata : sys_rdata;
	assign bus_addr = addr_reg;
	assign bus_wdata = bus_transfer_register;
	assign bus_write = write_reg;
	assign br_out = bus_transfer_register;
	// Only decode logic sees the instruction word
	assign dec_class = instruction_hold_register[`IR_CLASS];
	assign seq_variant = pick_variant(instruction_hold_register,
		dp_zero, dp_neg, dp_carry);
	assign trap_active = state_reg inside {ST_TR_PSW, ST_TR_PC,
		ST_TR_VPC, ST_TR_VPSW};
	assign dp_done = done_reg;
	assign ctx_load = ctx_reg;
	assign ctx_pc = pc_new_reg;
	assign sp_out = sp_reg;
	assign psw_out = psw_reg;
	assign ext_irq_ack = iack_reg;
	assign prdata = prdata_reg;
	assign pready = psel && penable && ce && lat_reg;
	assign irq = |(status_reg & mask_reg);

	assign cur_pri = psw_reg[`PSW_PRI];
	assign swi_lvl = top_level(swi_reg[`SWI_REQ]);
	assign spr_hit = dp_addr == `SPR_PSW || dp_addr == `SPR_SLIMIT ||
		dp_addr == `SPR_SWI;

	always_comb
	begin
		sel = CAUSE_NONE;
		// Fixed order: stack limit, device, software request
		if (stkov_reg)
			sel = CAUSE_STACK;
		else if (ext_irq && ext_irq_pri > cur_pri)
			sel = CAUSE_DEV;
		else if (swi_lvl > cur_pri)
			sel = CAUSE_SWI;
	end

	always_comb
	begin
		spr_rd = psw_reg;
		if (addr_reg == `SPR_SLIMIT)
			spr_rd = slimit_reg;
		else if (addr_reg == `SPR_SWI)
			spr_rd = swi_reg;
	end

	always_comb
	begin
		mapped = 1'b1;
		prdata_next = prdata_reg;
		unique case (paddr)
			`REG_CTRL: prdata_next = 32'(ctrl_reg);
			`REG_STATUS: prdata_next = 32'(status_reg);
			`REG_MASK: prdata_next = 32'(mask_reg);
			`REG_CAUSE: prdata_next = 32'(cause_reg);
			`REG_PSW: prdata_next = 32'(psw_reg);
			`REG_SLIMIT: prdata_next = 32'(slimit_reg);
			`REG_SWI: prdata_next = 32'(swi_reg);
			default:
			begin
				mapped = 1'b0;
				prdata_next = 32'h0000_0000;
			end
		endcase
		if (!psel)
			prdata_next = prdata_reg;
	end

	assign pslverr = psel && penable && ce && lat_reg && !mapped;
	assign apb_wr = pready && pwrite && mapped;
	assign apb_rd = pready && !pwrite;

	always_comb
	begin
		state_next = state_reg;
		cause_next = cause_reg;
		br_next = bus_transfer_register;
		ir_next = instruction_hold_register;
		psw_next = psw_reg;
		slimit_next = slimit_reg;
		swi_next = swi_reg;
		addr_next = addr_reg;
		sp_next = sp_reg;
		vec_next = vec_reg;
		pc_new_next = pc_new_reg;
		write_next = write_reg;
		fetch_next = fetch_reg;
		fast_next = fast_reg;
		stkov_next = stkov_reg;
		done_next = 1'b0;
		ctx_next = 1'b0;
		iack_next = 1'b0;
		events = '0;
		lat_next = psel && !pready;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				// Conditions are only taken between instructions
				if (instr_boundary && ctrl_reg[`CTRL_EN] &&
					sel != CAUSE_NONE)
				begin
					cause_next = sel;
					br_next = psw_reg;
					addr_next = sp_in - `WORD_STEP;
					sp_next = sp_in - `PUSH_TWO;
					write_next = 1'b1;
					fetch_next = 1'b0;
					fast_next = ctrl_reg[`CTRL_FAST];
					iack_next = sel == CAUSE_DEV;
					unique case (sel)
						CAUSE_STACK: vec_next = `VEC_STACK;
						CAUSE_DEV: vec_next = ext_irq_vec;
						default: vec_next = `VEC_SWI;
					endcase
					state_next = ST_TR_PSW;
				end
				// A request still held while done shows is the finished one
				else if (dp_req && !done_reg)
				begin
					addr_next = dp_addr;
					write_next = dp_write;
					fetch_next = dp_fetch && !dp_write;
					fast_next = dp_fast;
					if (dp_write)
						br_next = dp_wdata;
					if (dp_write && dp_addr < slimit_reg && !spr_hit)
						stkov_next = 1'b1;
					state_next = spr_hit ? ST_SPR : ST_DP;
				end
			end
			ST_DP:
			begin
				if (ack)
				begin
					if (!write_reg)
						br_next = in_word;
					if (fetch_reg)
					begin
						ir_next = in_word;
						events[`EV_FETCH] = 1'b1;
					end
					done_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			ST_SPR:
			begin
				// Processor accesses move special registers only through the transfer register
				if (write_reg)
				begin
					if (addr_reg == `SPR_SLIMIT)
						slimit_next = bus_transfer_register;
					else if (addr_reg == `SPR_SWI)
						swi_next = bus_transfer_register;
					else
						psw_next = bus_transfer_register;
				end
				else
					br_next = spr_rd;
				events[`EV_SPR] = 1'b1;
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
			ST_TR_PSW:
			begin
				if (ack)
				begin
					br_next = pc_in;
					addr_next = sp_reg;
					state_next = ST_TR_PC;
				end
			end
			ST_TR_PC:
			begin
				if (ack)
				begin
					write_next = 1'b0;
					addr_next = vec_reg;
					state_next = ST_TR_VPC;
				end
			end
			ST_TR_VPC:
			begin
				if (ack)
				begin
					br_next = in_word;
					pc_new_next = in_word;
					addr_next = vec_reg + `WORD_STEP;
					state_next = ST_TR_VPSW;
				end
			end
			ST_TR_VPSW:
			begin
				if (ack)
				begin
					br_next = in_word;
					psw_next = in_word;
					psw_next[`PSW_PMODE] = psw_reg[`PSW_CMODE];
					if (cause_reg == CAUSE_STACK)
						stkov_next = 1'b0;
					ctx_next = 1'b1;
					events[`EV_TRAP] = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		if (stkov_next && !stkov_reg)
			events[`EV_STKOV] = 1'b1;
		if (apb_wr && paddr == `REG_CTRL)
			ctrl_next = pwdata[`CTRL_W-1:0];
		if (apb_wr && paddr == `REG_MASK)
			mask_next = pwdata[`EV_W-1:0];
		// A new event in the clearing cycle survives the read
		status_next = status_reg;
		if (apb_rd && paddr == `REG_STATUS)
			status_next = '0;
		status_next = status_next | events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ST_IDLE;
			cause_reg <= CAUSE_NONE;
			bus_transfer_register <= '0;
			instruction_hold_register <= '0;
			psw_reg <= `PSW_RST;
			slimit_reg <= '0;
			swi_reg <= '0;
			addr_reg <= '0;
			sp_reg <= '0;
			vec_reg <= '0;
			pc_new_reg <= '0;
			write_reg <= 1'b0;
			fetch_reg <= 1'b0;
			fast_reg <= 1'b0;
			stkov_reg <= 1'b0;
			done_reg <= 1'b0;
			ctx_reg <= 1'b0;
			iack_reg <= 1'b0;
			ctrl_reg <= `CTRL_RST;
			status_reg <= '0;
			mask_reg <= '0;
			prdata_reg <= 32'h0000_0000;
			lat_reg <= 1'b0;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			cause_reg <= cause_next;
			bus_transfer_register <= br_next;
			instruction_hold_register <= ir_next;
			psw_reg <= psw_next;
			slimit_reg <= slimit_next;
			swi_reg <= swi_next;
			addr_reg <= addr_next;
			sp_reg <= sp_next;
			vec_reg <= vec_next;
			pc_new_reg <= pc_new_next;
			write_reg <= write_next;
			fetch_reg <= fetch_next;
			fast_reg <= fast_next;
			stkov_reg <= stkov_next;
			done_reg <= done_next;
			ctx_reg <= ctx_next;
			iack_reg <= iack_next;
			ctrl_reg <= ctrl_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			prdata_reg <= prdata_next;
			lat_reg <= lat_next;
		end
	end

endmodule : cpu_fetch_and_trap_control

`default_nettype wire

/* File: verilog/cpu_fetch_trap_consts.svh */
// Constants for the fetch, bus-transfer and trap control block.
// Assumes APB byte addressing with one aligned 32-bit word per register.
`ifndef CPU_FETCH_TRAP_CONSTS_SVH
`define CPU_FETCH_TRAP_CONSTS_SVH

// APB register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_CAUSE 8'h0C
`define REG_PSW 8'h10
`define REG_SLIMIT 8'h14
`define REG_SWI 8'h18

// Control register bits
`define CTRL_EN 0
`define CTRL_FAST 1
`define CTRL_W 2
`define CTRL_RST 2'h1

// Event bits, shared by status and mask
`define EV_TRAP 0
`define EV_STKOV 1
`define EV_FETCH 2
`define EV_SPR 3
`define EV_W 4

// Special register addresses on the processor side
`define SPR_PSW 16'hFFFE
`define SPR_SLIMIT 16'hFFFA
`define SPR_SWI 16'hFF7A

// Trap vectors and stack stepping
`define VEC_STACK 16'h0004
`define VEC_SWI 16'h00A0
`define WORD_STEP 16'h0002
`define PUSH_TWO 16'h0004

// Status word and software request fields
`define PSW_CMODE 15:14
`define PSW_PMODE 13:12
`define PSW_PRI 7:5
`define PSW_RST 16'h0000
`define SWI_REQ 15:9

// Instruction decode fields
`define IR_CLASS 15:12
`define IR_SELN 10
`define IR_SELZ 9
`define IR_INV 8
`define CLASS_BR 4'h0

`endif

/* File: verilog/cpu_fetch_trap_pkg.sv */
// Types for the fetch, bus-transfer and trap control block.
// Assumes nothing of its surroundings.
package cpu_fetch_trap_pkg;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_DP,
		ST_SPR,
		ST_TR_PSW,
		ST_TR_PC,
		ST_TR_VPC,
		ST_TR_VPSW
	} ctl_state_t;

	typedef enum logic [1:0]
	{
		CAUSE_NONE,
		CAUSE_STACK,
		CAUSE_DEV,
		CAUSE_SWI
	} cause_t;

endpackage : cpu_fetch_trap_pkg
